/* File: shared/ppfw_pkg.sv */
/*
 Constants, register map and field layout of the port pin function block.
 Assumes an AXI4-Lite master on core_clk and package pins outside.
*/
// Overview of operation
// - Pins: input or push-pull output, pull-up
// - Port A bit 5 open-drain only
// - Wake-up gated by digital-input-enable bit
// - Line zero interrupts on both edges
// - Port A bit 5: reset or wavegen two
// - A3 timer two, A0 comparator output
// - B7 timer three or wavegen one
// - A0 wavegen zero, A3 wavegen two
// - Comparator inputs routed from A3, B7, A4
// - A0 comparator output besides I/O, interrupt
package ppfw_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PA_DATA = 8'h00;
   localparam logic [7:0] OFS_PA_DIR = 8'h04;
   localparam logic [7:0] OFS_PA_PULL = 8'h08;
   localparam logic [7:0] OFS_PA_DIE = 8'h0c;
   localparam logic [7:0] OFS_PB_DATA = 8'h10;
   localparam logic [7:0] OFS_PB_DIR = 8'h14;
   localparam logic [7:0] OFS_PB_PULL = 8'h18;
   localparam logic [7:0] OFS_PB_DIE = 8'h1c;
   localparam logic [7:0] OFS_PA_IN = 8'h20;
   localparam logic [7:0] OFS_PB_IN = 8'h24;
   localparam logic [7:0] OFS_ALT = 8'h28;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
   localparam logic [7:0] OFS_CMP_SEL = 8'h34;
   localparam logic [7:0] OFS_WAKE_EN = 8'h38;
   // ----------------------------------------------------------------
   // Alternate function enable bits
   // ----------------------------------------------------------------
   localparam int ALT_XTAL = 0;
   localparam int ALT_RESET = 1;
   localparam int ALT_A5_WG2 = 2;
   localparam int ALT_A3_WG2 = 3;
   localparam int ALT_A3_TM2 = 4;
   localparam int ALT_A0_CMP = 5;
   localparam int ALT_A0_WG0 = 6;
   localparam int ALT_B7_TM3 = 7;
   localparam int ALT_B7_WG1 = 8;
   localparam int ALT_W = 9;
   // ----------------------------------------------------------------
   // Status bits, pin indices, comparator sources
   // ----------------------------------------------------------------
   localparam int ST_EDGE = 0;
   localparam int ST_WAKE = 1;
   localparam int ST_W = 2;
   localparam int PIN_0 = 0;
   localparam int PIN_3 = 3;
   localparam int PIN_4 = 4;
   localparam int PIN_5 = 5;
   localparam int PIN_7 = 7;
   localparam logic [2:0] CMP_SRC_ONE = 3'h1;
   localparam logic [2:0] CMP_SRC_THREE = 3'h3;
   localparam logic [2:0] CMP_SRC_FOUR = 3'h4;
   localparam logic [7:0] DIE_RESET = 8'hff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/ppfw_sync.sv */
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfw_sync #(parameter int W = 8) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= '0;
         sync_out <= '0;
      end else begin
         stage_reg <= async_in;
         sync_out <= stage_reg;
      end
   end
endmodule // ppfw_sync
`default_nettype wire

/* File: logic/ppfw_pin.sv */
/*
 One pad's output stage: direction, pull-up, open-drain and alternate drive.
 Assumes the alternate select is already resolved by priority.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfw_pin #(parameter bit OPEN_DRAIN = 1'b0) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic out_dir,
   input wire logic out_data,
   input wire logic pull_en,
   input wire logic alt_sel,
   input wire logic alt_data,
   input wire logic hold_off,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pull
);
   logic val;
   logic drive;
   always_comb begin
      val = alt_sel ? alt_data : out_data;
      drive = !hold_off && (alt_sel || out_dir);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pad_pull <= 1'b0;
      end else if (OPEN_DRAIN) begin
         pad_out <= 1'b0;
         pad_oe <= drive && !val;
         pad_pull <= pull_en && !hold_off;
      end else begin
         pad_out <= val;
         pad_oe <= drive;
         pad_pull <= pull_en && !hold_off;
      end
   end
endmodule // ppfw_pin
`default_nettype wire

/* File: logic/ppfw_top.sv */
/*
 Port A/B pin function block with AXI4-Lite register slave.
 Assumes pins arrive asynchronous; peripherals run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfw_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] pa_pad_in,
   output logic [7:0] pa_pad_out,
   output logic [7:0] pa_pad_oe,
   output logic [7:0] pa_pad_pull,
   input wire logic [7:0] pb_pad_in,
   output logic [7:0] pb_pad_out,
   output logic [7:0] pb_pad_oe,
   output logic [7:0] pb_pad_pull,
   input wire logic sleeping,
   input wire logic timer_two_wave_out,
   input wire logic timer_three_wave_out,
   input wire logic wavegen_zero_out,
   input wire logic wavegen_one_out,
   input wire logic wavegen_two_out,
   input wire logic comparator_result_out,
   output logic comparator_pos_in,
   output logic comparator_neg_in,
   output logic external_reset_in_n,
   output logic xtal_in_pin,
   output logic xtal_out_pin,
   output logic ext_irq_line_zero,
   output logic wake_up,
   output logic irq
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] pa_data_reg, pa_dir_reg, pa_pull_reg, pa_die_reg;
   logic [7:0] pb_data_reg, pb_dir_reg, pb_pull_reg, pb_die_reg;
   logic [ppfw_pkg::ALT_W-1:0] alt_reg;
   logic [ppfw_pkg::ST_W-1:0] stat_reg, mask_reg;
   logic [2:0] cmp_sel_reg;
   logic [7:0] pa_wake_reg, pb_wake_reg;
   logic [7:0] pa_sync, pb_sync, pa_last_reg, pb_last_reg;
   logic a0_prev_reg;
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   ppfw_sync #(.W(8)) u_sync_a (
      .clk(core_clk),
      .reset_n(reset_n),
      .async_in(pa_pad_in),
      .sync_out(pa_sync)
   );
   ppfw_sync #(.W(8)) u_sync_b (
      .clk(core_clk),
      .reset_n(reset_n),
      .async_in(pb_pad_in),
      .sync_out(pb_sync)
   );
   // ----------------------------------------------------------------
   // Alternate output selection with fixed priority
   // ----------------------------------------------------------------
   logic [7:0] pa_alt_sel, pa_alt_val, pb_alt_sel, pb_alt_val, pa_hold;
   always_comb begin
      pa_alt_sel = '0;
      pa_alt_val = '0;
      pb_alt_sel = '0;
      pb_alt_val = '0;
      pa_hold = '0;
      // Port A bit 5: reset role wins and releases the pad
      if (alt_reg[ppfw_pkg::ALT_RESET]) begin
         pa_hold[ppfw_pkg::PIN_5] = 1'b1;
      end else if (alt_reg[ppfw_pkg::ALT_A5_WG2]) begin
         pa_alt_sel[ppfw_pkg::PIN_5] = 1'b1;
         pa_alt_val[ppfw_pkg::PIN_5] = wavegen_two_out;
      end
      // Crystal pins are never driven digitally
      if (alt_reg[ppfw_pkg::ALT_XTAL]) begin
         pa_hold[7:6] = 2'h3;
      end
      // Port A bit 3: wavegen two over timer two
      if (alt_reg[ppfw_pkg::ALT_A3_WG2]) begin
         pa_alt_sel[ppfw_pkg::PIN_3] = 1'b1;
         pa_alt_val[ppfw_pkg::PIN_3] = wavegen_two_out;
      end else if (alt_reg[ppfw_pkg::ALT_A3_TM2]) begin
         pa_alt_sel[ppfw_pkg::PIN_3] = 1'b1;
         pa_alt_val[ppfw_pkg::PIN_3] = timer_two_wave_out;
      end
      // Port A bit 0: comparator over wavegen zero
      if (alt_reg[ppfw_pkg::ALT_A0_CMP]) begin
         pa_alt_sel[ppfw_pkg::PIN_0] = 1'b1;
         pa_alt_val[ppfw_pkg::PIN_0] = comparator_result_out;
      end else if (alt_reg[ppfw_pkg::ALT_A0_WG0]) begin
         pa_alt_sel[ppfw_pkg::PIN_0] = 1'b1;
         pa_alt_val[ppfw_pkg::PIN_0] = wavegen_zero_out;
      end
      // Port B bit 7: wavegen one over timer three
      if (alt_reg[ppfw_pkg::ALT_B7_WG1]) begin
         pb_alt_sel[ppfw_pkg::PIN_7] = 1'b1;
         pb_alt_val[ppfw_pkg::PIN_7] = wavegen_one_out;
      end else if (alt_reg[ppfw_pkg::ALT_B7_TM3]) begin
         pb_alt_sel[ppfw_pkg::PIN_7] = 1'b1;
         pb_alt_val[ppfw_pkg::PIN_7] = timer_three_wave_out;
      end
   end
   // ----------------------------------------------------------------
   // Pad stages
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pad
         ppfw_pin #(.OPEN_DRAIN(gi == ppfw_pkg::PIN_5)) u_pa (
            .clk(core_clk),
            .reset_n(reset_n),
            .out_dir(pa_dir_reg[gi]),
            .out_data(pa_data_reg[gi]),
            .pull_en(pa_pull_reg[gi]),
            .alt_sel(pa_alt_sel[gi]),
            .alt_data(pa_alt_val[gi]),
            .hold_off(pa_hold[gi]),
            .pad_out(pa_pad_out[gi]),
            .pad_oe(pa_pad_oe[gi]),
            .pad_pull(pa_pad_pull[gi])
         );
         ppfw_pin #(.OPEN_DRAIN(1'b0)) u_pb (
            .clk(core_clk),
            .reset_n(reset_n),
            .out_dir(pb_dir_reg[gi]),
            .out_data(pb_data_reg[gi]),
            .pull_en(pb_pull_reg[gi]),
            .alt_sel(pb_alt_sel[gi]),
            .alt_data(pb_alt_val[gi]),
            .hold_off(1'b0),
            .pad_out(pb_pad_out[gi]),
            .pad_oe(pb_pad_oe[gi]),
            .pad_pull(pb_pad_pull[gi])
         );
      end
   endgenerate
   // ----------------------------------------------------------------
   // Gated digital inputs, wake-up and edge interrupt
   // ----------------------------------------------------------------
   logic [7:0] pa_in_g, pb_in_g;
   logic wake_hit, edge_hit;
   always_comb begin
      pa_in_g = pa_sync & pa_die_reg;
      pb_in_g = pb_sync & pb_die_reg;
      wake_hit = sleeping && (|((pa_in_g ^ pa_last_reg) & pa_wake_reg & pa_die_reg)
         || |((pb_in_g ^ pb_last_reg) & pb_wake_reg & pb_die_reg));
      edge_hit = pa_in_g[ppfw_pkg::PIN_0] ^ a0_prev_reg;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pa_last_reg <= '0;
         pb_last_reg <= '0;
         a0_prev_reg <= 1'b0;
      end else begin
         pa_last_reg <= pa_in_g;
         pb_last_reg <= pb_in_g;
         a0_prev_reg <= pa_in_g[ppfw_pkg::PIN_0];
      end
   end
   // ----------------------------------------------------------------
   // Side outputs to peripherals
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         comparator_pos_in <= 1'b0;
         comparator_neg_in <= 1'b0;
         external_reset_in_n <= 1'b1;
         xtal_in_pin <= 1'b0;
         xtal_out_pin <= 1'b0;
         ext_irq_line_zero <= 1'b0;
         wake_up <= 1'b0;
         irq <= 1'b0;
      end else begin
         comparator_pos_in <= pa_sync[ppfw_pkg::PIN_4];
         unique case (cmp_sel_reg)
            ppfw_pkg::CMP_SRC_ONE: comparator_neg_in <= pa_sync[ppfw_pkg::PIN_3];
            ppfw_pkg::CMP_SRC_THREE: comparator_neg_in <= pb_sync[ppfw_pkg::PIN_7];
            ppfw_pkg::CMP_SRC_FOUR: comparator_neg_in <= pa_sync[ppfw_pkg::PIN_4];
            default: comparator_neg_in <= 1'b0;
         endcase
         external_reset_in_n <= !alt_reg[ppfw_pkg::ALT_RESET]
            || pa_sync[ppfw_pkg::PIN_5];
         // Crystal pins bypass the input enable; it is software's to clear
         xtal_in_pin <= alt_reg[ppfw_pkg::ALT_XTAL] && pa_sync[ppfw_pkg::PIN_7];
         xtal_out_pin <= alt_reg[ppfw_pkg::ALT_XTAL] && pa_sync[6];
         ext_irq_line_zero <= edge_hit;
         wake_up <= wake_hit;
         irq <= |(stat_reg & mask_reg);
      end
   end
   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic aw_held_reg, w_held_reg, wstrb_lo_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic do_write, write_ok;
   always_comb begin
      do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
      unique case (awaddr_reg)
         ppfw_pkg::OFS_PA_DATA, ppfw_pkg::OFS_PA_DIR, ppfw_pkg::OFS_PA_PULL,
         ppfw_pkg::OFS_PA_DIE, ppfw_pkg::OFS_PB_DATA, ppfw_pkg::OFS_PB_DIR,
         ppfw_pkg::OFS_PB_PULL, ppfw_pkg::OFS_PB_DIE, ppfw_pkg::OFS_ALT,
         ppfw_pkg::OFS_IRQ_STAT, ppfw_pkg::OFS_IRQ_MASK, ppfw_pkg::OFS_CMP_SEL,
         ppfw_pkg::OFS_WAKE_EN: write_ok = 1'b1;
         default: write_ok = 1'b0;
      endcase
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_lo_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ppfw_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_lo_reg <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_ok ? ppfw_pkg::RESP_OKAY : ppfw_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pa_data_reg <= '0;
         pa_dir_reg <= '0;
         pa_pull_reg <= '0;
         pa_die_reg <= ppfw_pkg::DIE_RESET;
         pb_data_reg <= '0;
         pb_dir_reg <= '0;
         pb_pull_reg <= '0;
         pb_die_reg <= ppfw_pkg::DIE_RESET;
         alt_reg <= '0;
         mask_reg <= '0;
         cmp_sel_reg <= '0;
         pa_wake_reg <= '0;
         pb_wake_reg <= '0;
      end else if (do_write && wstrb_lo_reg) begin
         unique case (awaddr_reg)
            ppfw_pkg::OFS_PA_DATA: pa_data_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PA_DIR: pa_dir_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PA_PULL: pa_pull_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PA_DIE: pa_die_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PB_DATA: pb_data_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PB_DIR: pb_dir_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PB_PULL: pb_pull_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_PB_DIE: pb_die_reg <= wdata_reg[7:0];
            ppfw_pkg::OFS_ALT: alt_reg <= wdata_reg[ppfw_pkg::ALT_W-1:0];
            ppfw_pkg::OFS_IRQ_MASK: mask_reg <= wdata_reg[ppfw_pkg::ST_W-1:0];
            ppfw_pkg::OFS_CMP_SEL: cmp_sel_reg <= wdata_reg[2:0];
            ppfw_pkg::OFS_WAKE_EN: begin
               pa_wake_reg <= wdata_reg[7:0];
               pb_wake_reg <= wdata_reg[15:8];
            end
            default: ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Sticky status, set wins over clear
   // ----------------------------------------------------------------
   logic [ppfw_pkg::ST_W-1:0] stat_set, stat_clr;
   always_comb begin
      stat_set = '0;
      stat_set[ppfw_pkg::ST_EDGE] = edge_hit;
      stat_set[ppfw_pkg::ST_WAKE] = wake_hit;
      stat_clr = '0;
      if (do_write && wstrb_lo_reg && awaddr_reg == ppfw_pkg::OFS_IRQ_STAT) begin
         stat_clr = wdata_reg[ppfw_pkg::ST_W-1:0];
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_reg <= '0;
      end else begin
         stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      end
   end
   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic [31:0] rd_val;
   logic rd_ok;
   always_comb begin
      rd_val = '0;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         ppfw_pkg::OFS_PA_DATA: rd_val[7:0] = pa_data_reg;
         ppfw_pkg::OFS_PA_DIR: rd_val[7:0] = pa_dir_reg;
         ppfw_pkg::OFS_PA_PULL: rd_val[7:0] = pa_pull_reg;
         ppfw_pkg::OFS_PA_DIE: rd_val[7:0] = pa_die_reg;
         ppfw_pkg::OFS_PB_DATA: rd_val[7:0] = pb_data_reg;
         ppfw_pkg::OFS_PB_DIR: rd_val[7:0] = pb_dir_reg;
         ppfw_pkg::OFS_PB_PULL: rd_val[7:0] = pb_pull_reg;
         ppfw_pkg::OFS_PB_DIE: rd_val[7:0] = pb_die_reg;
         ppfw_pkg::OFS_PA_IN: rd_val[7:0] = pa_in_g;
         ppfw_pkg::OFS_PB_IN: rd_val[7:0] = pb_in_g;
         ppfw_pkg::OFS_ALT: rd_val[ppfw_pkg::ALT_W-1:0] = alt_reg;
         ppfw_pkg::OFS_IRQ_STAT: rd_val[ppfw_pkg::ST_W-1:0] = stat_reg;
         ppfw_pkg::OFS_IRQ_MASK: rd_val[ppfw_pkg::ST_W-1:0] = mask_reg;
         ppfw_pkg::OFS_CMP_SEL: rd_val[2:0] = cmp_sel_reg;
         ppfw_pkg::OFS_WAKE_EN: rd_val[15:0] = {pb_wake_reg, pa_wake_reg};
         default: rd_ok = 1'b0;
      endcase
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ppfw_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? ppfw_pkg::RESP_OKAY : ppfw_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ppfw_top
`default_nettype wire

/* File: tb/ppfw_monitor.sv */
/*
 Port checker.
 Assumes binding into ppfw_top, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfw_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] pa_pad_in,
   input wire logic [7:0] pa_pad_out,
   input wire logic sleeping,
   input wire logic comparator_pos_in,
   input wire logic external_reset_in_n,
   input wire logic ext_irq_line_zero,
   input wire logic wake_up,
   input wire logic irq
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_pa5_never_high: assert property (!pa_pad_out[5])
      else $error("pa5 driven high");
   a_edge_has_cause: assert property (ext_irq_line_zero |->
      ($past(pa_pad_in[0], 3) != $past(pa_pad_in[0], 4)) ||
      ($past(pa_pad_in[0], 2) != $past(pa_pad_in[0], 3)))
      else $error("edge without cause");
   a_wake_in_sleep: assert property (wake_up |-> $past(sleeping))
      else $error("wake while awake");
   a_reset_follows_pin: assert property (!external_reset_in_n |->
      !$past(pa_pad_in[5], 2) || !$past(pa_pad_in[5], 3))
      else $error("reset low, pin high");
   a_cmp_pos_pin: assert property ($changed(comparator_pos_in) |->
      $past(pa_pad_in[4], 2) == comparator_pos_in ||
      $past(pa_pad_in[4], 3) == comparator_pos_in)
      else $error("pos not from pa4");
   a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   a_r_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stuck");
   a_ready_pulse: assert property (s_axi_awready || s_axi_arready |=>
      !s_axi_awready && !s_axi_arready)
      else $error("ready too long");
   c_edge: cover property (ext_irq_line_zero);
   c_wake: cover property (wake_up);
   c_irq: cover property ($rose(irq));
endmodule // ppfw_monitor
bind ppfw_top ppfw_monitor mon (.core_clk(core_clk), .reset_n(reset_n),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pa_pad_in(pa_pad_in), .pa_pad_out(pa_pad_out), .sleeping(sleeping),
   .comparator_pos_in(comparator_pos_in), .external_reset_in_n(external_reset_in_n),
   .ext_irq_line_zero(ext_irq_line_zero), .wake_up(wake_up), .irq(irq));
`default_nettype wire

/* File: tb/ppfw_pads.sv */
/*
 Pad model: chip drive, board drive or pull-up.
 Assumes a floating pad flips every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ppfw_pads (
   input wire logic core_clk,
   input wire logic [7:0] pa_pad_out,
   input wire logic [7:0] pa_pad_oe,
   input wire logic [7:0] pa_pad_pull,
   input wire logic [7:0] pb_pad_out,
   input wire logic [7:0] pb_pad_oe,
   input wire logic [7:0] pb_pad_pull,
   input wire logic [7:0] pa_drv,
   input wire logic [7:0] pb_drv,
   input wire logic drv_en,
   output logic [7:0] pa_pad_in,
   output logic [7:0] pb_pad_in
);
   // ----------
   // Pad resolution
   // ----------
   logic [7:0] flip = 8'h00;
   always @(posedge core_clk) flip <= ~flip;
   function automatic logic [7:0] lvl(input logic [7:0] o, e, p, d);
      return (e & o) | (~e & (drv_en ? d : (p | flip)));
   endfunction
   assign pa_pad_in = lvl(pa_pad_out, pa_pad_oe, pa_pad_pull, pa_drv);
   assign pb_pad_in = lvl(pb_pad_out, pb_pad_oe, pb_pad_pull, pb_drv);
endmodule // ppfw_pads
`default_nettype wire

/* File: tb/tb.sv */
/*
 Self-checking bench.
 Assumes the pad model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ----------
   // Setup
   // ----------
   logic core_clk = 1'h0, reset_n = 1'h0, drv_en = 1'h1, sleeping = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pa_drv = 8'h00, pb_drv = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, comparator_result_out = 1'h0;
   logic timer_two_wave_out = 1'h1, timer_three_wave_out = 1'h1, wavegen_zero_out = 1'h1;
   logic wavegen_one_out = 1'h0, wavegen_two_out = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic comparator_pos_in, comparator_neg_in, external_reset_in_n, xtal_in_pin;
   logic xtal_out_pin, ext_irq_line_zero, wake_up, irq, h;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] d;
   logic [7:0] pa_pad_in, pa_pad_out, pa_pad_oe, pa_pad_pull;
   logic [7:0] pb_pad_in, pb_pad_out, pb_pad_oe, pb_pad_pull;
   wire [15:0] oe_all = {pb_pad_oe, pa_pad_oe};
   wire [15:0] out_all = {pb_pad_out, pa_pad_out};
   int miscompares = 0, check_count = 0;
   ppfw_top uut (.*);
   ppfw_pads pads (.*);
   always #25 core_clk = ~core_clk;
   task automatic cyc(input int n); repeat (n) @(posedge core_clk); endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp; s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'h0;
   endtask
   task automatic pulse(input bit w);
      h = 1'h0;
      repeat (8) begin @(posedge core_clk); #1 h |= w ? wake_up : ext_irq_line_zero; end
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic t_regs;
      rd(8'h0c); chk("pa die", d, 32'hff);
      rd(8'h1c); chk("pb die", d, 32'hff);
      rd(8'h3c); chk("rd err", r, 2'h2);
      wr(8'h3c, 32'h1); chk("wr err", r, 2'h2);
      $display("regs done");
   endtask
   task automatic t_pins;
      wr(8'h04, 32'hff); wr(8'h00, 32'ha5); wr(8'h08, 32'h0f); cyc(2);
      chk("out", pa_pad_out, 8'h85); chk("oe", pa_pad_oe, 8'hdf);
      chk("pull", pa_pad_pull, 8'h0f);
      wr(8'h00, 32'h00); cyc(2); chk("oe low", pa_pad_oe, 8'hff);
      wr(8'h04, 32'h00); pa_drv <= 8'h3c; cyc(4);
      rd(8'h20); chk("input", d, 32'h3c);
      $display("pins done");
   endtask
   task automatic t_alt;
      logic [8:0] alts [8] = '{9'h010, 9'h018, 9'h040, 9'h060, 9'h080, 9'h180, 9'h004, 9'h006};
      int pins [8] = '{3, 3, 0, 0, 15, 15, 5, 5};
      logic [1:0] ex [8] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h0};
      pa_drv <= 8'h00;
      for (int i = 0; i < 8; i++) begin
         wr(8'h28, {23'h0, alts[i]}); cyc(2);
         chk("alt", {oe_all[pins[i]], out_all[pins[i]]}, ex[i]);
      end
      cyc(4); chk("rst low", external_reset_in_n, 1'h0);
      pa_drv <= 8'h20; cyc(4); chk("rst high", external_reset_in_n, 1'h1);
      wr(8'h28, 32'h1); wr(8'h04, 32'hff); pa_drv <= 8'h80; cyc(4);
      chk("xin", xtal_in_pin, 1'h1); chk("xout", xtal_out_pin, 1'h0);
      chk("x oe", pa_pad_oe[7:6], 2'h0);
      wr(8'h0c, 32'h3f); rd(8'h20); chk("gated", d[7:6], 2'h0);
      wr(8'h28, 32'h0); wr(8'h04, 32'h0); wr(8'h0c, 32'hff);
      $display("alt done");
   endtask
   task automatic t_cmp;
      for (int p = 0; p < 2; p++) begin
         pa_drv <= {3'h0, p[0], p[0], 3'h0}; pb_drv <= {~p[0], 7'h0};
         for (int s = 1; s < 5; s++) begin
            wr(8'h34, s); cyc(4);
            chk("neg", comparator_neg_in, s == 3 ? !p[0] : s == 2 ? 1'h0 : p[0]);
            chk("pos", comparator_pos_in, p[0]);
         end
      end
      $display("cmp done");
   endtask
   task automatic t_edge;
      wr(8'h30, 32'h0); pa_drv <= 8'h01; pulse(0); chk("rise", h, 1'h1);
      rd(8'h2c); chk("stat", d[0], 1'h1); chk("masked", irq, 1'h0);
      wr(8'h30, 32'h3); cyc(2); chk("irq", irq, 1'h1);
      wr(8'h2c, 32'h3); cyc(2); chk("cleared", irq, 1'h0);
      pa_drv <= 8'h00; pulse(0); chk("fall", h, 1'h1);
      wr(8'h0c, 32'hfe); pa_drv <= 8'h01; pulse(0); chk("gate", h, 1'h0);
      $display("edge done");
   endtask
   task automatic t_wake;
      wr(8'h38, 32'h10); sleeping <= 1'h1; pa_drv <= 8'h11;
      pulse(1); chk("wake", h, 1'h1);
      rd(8'h2c); chk("wake stat", d[1], 1'h1);
      wr(8'h0c, 32'hee); pa_drv <= 8'h01; pulse(1); chk("no wake", h, 1'h0);
      sleeping <= 1'h0;
      $display("wake done");
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(20); reset_n <= 1'h1;
      t_regs; t_pins; t_alt; t_cmp; t_edge; t_wake;
      close_out;
   end
   initial begin
      cyc(20000); miscompares++; close_out;
   end
endmodule // tb
`default_nettype wire
